// ==== core/coc_pkg.sv ====
// Purpose: Shared constants and types for the clock output control block
// Assumes: 10 MHz system clock, digital model of output stage
// Notes: All widths and counts named here
package coc_pkg;
    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int NUM_DIV = 5;
    localparam int NUM_OUT = 10;
    localparam int SEL_W = 3;
    localparam int STEP_W = 44;
    localparam int NUM_W = 44;
    localparam int SKEW_W = 16;
    localparam int DRV_W = 2;
    localparam int RDIV_W = 8;
    localparam int NVM_WRITES_MAX = 2;
    localparam int NVM_CNT_W = 2;
    // ************************************************************
    // Encodings and reset values
    // ************************************************************
    localparam logic [DRV_W-1:0] DRV_LOWEST = 2'h1;
    localparam logic [DRV_W-1:0] DRV_RESET = 2'h3;
    localparam logic [1:0] VDDO_1V8 = 2'h2;
    localparam logic [NVM_CNT_W-1:0] NVM_CNT_RESET = 2'h0;
    localparam logic [SKEW_W-1:0] SKEW_DEFAULT = 16'h0000;
    localparam logic [RDIV_W-1:0] RDIV_DEFAULT = 8'h02;
    // Per-output configuration
    typedef struct packed {
        logic reg_disable;
        logic disable_high;
        logic async_disable;
        logic is_cmos;
        logic cmos_in_phase;
        logic [DRV_W-1:0] cmos_drive_select;
        logic [SEL_W-1:0] src_sel;
    } coc_out_cfg_s;
    // Output pin pair
    typedef struct packed {
        logic true_output;
        logic complementary_output;
        logic driver_on;
    } coc_pin_s;
    // Disable sequencer states
    typedef enum logic [2:0] {
        ST_ON = 3'h1,
        ST_WAIT = 3'h2,
        ST_OFF = 3'h4
    } coc_dis_e;
endpackage

// ==== core/coc_edge_sync.sv ====
// Purpose: Two-flop synchroniser with rising edge pulse
// Assumes: Asynchronous pin input
// Notes: First flop feeds only the second
`timescale 1ns/100ps
`default_nettype none
module coc_edge_sync (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Pin and result
    input wire logic pin_i,
    output logic level_o,
    output logic rise_o
);
    logic meta;
    logic sync;
    logic prev;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= pin_i;
            sync <= meta;
            prev <= sync;
        end
    end
    assign level_o = sync;
    assign rise_o = sync & ~prev;
endmodule
`default_nettype wire

// ==== core/coc_out_driver.sv ====
// Purpose: One output driver with disable sequencing and polarity
// Assumes: Source clock sampled on clk_i
// Notes: Sync disable waits for a falling edge of the source clock as end of period
`timescale 1ns/100ps
`default_nettype none
module coc_out_driver (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Control
    input wire logic global_off_i,
    input wire coc_pkg::coc_out_cfg_s cfg_i,
    input wire logic src_clk_i,
    // Pins
    output coc_pkg::coc_pin_s pin_o
);
    coc_pkg::coc_dis_e state;
    coc_pkg::coc_dis_e next_state;
    logic src_prev;
    wire want_off = global_off_i | cfg_i.reg_disable; // [RQ1] [RQ2]
    wire period_end = src_prev & ~src_clk_i;
    always_comb begin
        case (state)
            coc_pkg::ST_ON: begin
                if (want_off && cfg_i.async_disable) begin
                    next_state = coc_pkg::ST_OFF; // [RQ6]
                end else if (want_off) begin
                    next_state = coc_pkg::ST_WAIT;
                end else begin
                    next_state = coc_pkg::ST_ON;
                end
            end
            coc_pkg::ST_WAIT: begin
                if (!want_off) begin
                    next_state = coc_pkg::ST_ON;
                end else if (period_end || cfg_i.async_disable) begin
                    next_state = coc_pkg::ST_OFF; // [RQ5]
                end else begin
                    next_state = coc_pkg::ST_WAIT;
                end
            end
            coc_pkg::ST_OFF: begin
                if (!want_off) begin
                    next_state = coc_pkg::ST_ON;
                end else begin
                    next_state = coc_pkg::ST_OFF;
                end
            end
            default: next_state = coc_pkg::ST_OFF;
        endcase
    end
    wire run = (state != coc_pkg::ST_OFF);
    wire level_off = cfg_i.disable_high; // [RQ3]
    wire next_true = run ? src_clk_i : level_off;
    wire next_comp = run ? (cfg_i.is_cmos && cfg_i.cmos_in_phase ? src_clk_i : ~src_clk_i)
        : level_off; // [RQ7]
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= coc_pkg::ST_OFF;
            src_prev <= 1'b0;
            pin_o <= '0;
        end else begin
            state <= next_state;
            src_prev <= src_clk_i;
            pin_o.true_output <= next_true;
            pin_o.complementary_output <= next_comp;
            pin_o.driver_on <= run;
        end
    end
    // ************************************************************
    // Checks
    // ************************************************************
    property p_async_off;
        @(posedge clk_i) disable iff (!resetn_i)
        (state == coc_pkg::ST_ON && want_off && cfg_i.async_disable) |=> ##1 !pin_o.driver_on;
    endproperty
    a_async_off: assert property (p_async_off) else $error("async disable late"); // [RQ6]
    property p_sync_wait;
        @(posedge clk_i) disable iff (!resetn_i)
        (state == coc_pkg::ST_WAIT && !period_end && want_off && !cfg_i.async_disable)
        |=> state == coc_pkg::ST_WAIT;
    endproperty
    a_sync_wait: assert property (p_sync_wait) else $error("sync disable cut period"); // [RQ5]
    property p_off_level;
        @(posedge clk_i) disable iff (!resetn_i)
        (state == coc_pkg::ST_OFF) && $stable(cfg_i.disable_high)
        |=> pin_o.true_output == $past(cfg_i.disable_high);
    endproperty
    a_off_level: assert property (p_off_level) else $error("disabled level wrong"); // [RQ3]
    property p_global_off;
        @(posedge clk_i) disable iff (!resetn_i)
        global_off_i [*2] ##1 global_off_i |-> !pin_o.driver_on || state != coc_pkg::ST_ON;
    endproperty
    a_global_off: assert property (p_global_off) else $error("driver on while pin off"); // [RQ1]
endmodule
`default_nettype wire

// ==== core/coc_top.sv ====
// Purpose: Output stage control of a multi-output clock generator
// Assumes: Pins asynchronous; configuration ports steady from host logic
// Notes: Dividers are modelled digitally on clk_i
// Function
// [RQ1] Output-disable pin high forces every driver into its disabled state.
// [RQ2] Pin low enables outputs unless individually disabled by configuration.
// [RQ3] Each output chooses static low or high when disabled.
// [RQ4] Per output sync or async disable; sync by default after reset.
// [RQ5] Sync disable waits for the running period end, no runt.
// [RQ6] Async disable turns the driver off at once.
// [RQ7] CMOS drives both pins, inverted by default, optionally in phase.
// [RQ8] Drive select per driver; lowest setting barred at lowest supply.
// [RQ9] Five dividers each have a skew delay setting.
// [RQ10] Host sets soft reset after skew changes so delays take effect.
// [RQ11] Power-up or hard reset reloads skew settings from stored values.
// [RQ12] Power-up or hard reset returns output dividers to stored state.
// [RQ13] Sync pin rising edge realigns output dividers without reset.
// [RQ14] Sync control bit performs the same realignment.
// [RQ15] Soft reset realigns outputs using the skew settings.
// [RQ16] Crosspoint sources each output from any divider.
// [RQ17] Step up or down changes a divider frequency by step word.
// [RQ18] Frequency changes apply to all fed outputs without glitches.
// [RQ19] Numerator applies only on its update write, glitch-free.
// [RQ20] Zero-delay mode selects external feedback input for the loop.
// [RQ21] Stored configuration accepts at most two writes; old one lost.
// [RQ22] Select pin chooses I2C or SPI; SPI has 4-wire or 3-wire forms.
// [RQ23] Sync and step pins synchronised and edge detected, one action each.

`timescale 1ns/100ps
`default_nettype none
module coc_top #(
    parameter int NUM_DIV = coc_pkg::NUM_DIV,
    parameter int NUM_OUT = coc_pkg::NUM_OUT
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Device pins
    input wire logic output_disable_pin_n_i,
    input wire logic realign_pin_n_i,
    input wire logic hard_reset_pin_n_i,
    input wire logic freq_step_up_i,
    input wire logic freq_step_down_i,
    input wire logic serial_sel_pin_i,
    input wire logic [NUM_DIV-1:0] feedback_input_i,
    // Configuration
    input wire coc_pkg::coc_out_cfg_s [NUM_OUT-1:0] out_cfg_i,
    input wire logic [1:0] vddo_level_i,
    input wire logic [NUM_DIV-1:0][coc_pkg::SKEW_W-1:0] divider_skew_setting_i,
    input wire logic [NUM_DIV-1:0][coc_pkg::SKEW_W-1:0] nvm_skew_i,
    input wire logic [coc_pkg::STEP_W-1:0] freq_step_word_i,
    input wire logic [NUM_DIV-1:0] step_target_i,
    input wire logic step_up_bit_i,
    input wire logic step_down_bit_i,
    input wire logic [coc_pkg::NUM_W-1:0] numerator_i,
    input wire logic [coc_pkg::SEL_W-1:0] numerator_div_i,
    input wire logic numerator_update_i,
    input wire logic soft_reset_bit_i,
    input wire logic hard_reset_bit_i,
    input wire logic sync_bit_i,
    input wire logic zero_delay_i,
    input wire logic nvm_write_i,
    input wire logic spi_3wire_i,
    // Divider clocks in
    input wire logic [NUM_DIV-1:0] div_clk_i,
    // Outputs
    output coc_pkg::coc_pin_s [NUM_OUT-1:0] pin_o,
    output logic [NUM_DIV-1:0][coc_pkg::NUM_W-1:0] numerator_o,
    output logic [NUM_DIV-1:0][coc_pkg::SKEW_W-1:0] applied_skew_o,
    output logic [NUM_OUT-1:0][coc_pkg::RDIV_W-1:0] rdiv_count_o,
    output logic [NUM_OUT-1:0][coc_pkg::DRV_W-1:0] drive_applied_o,
    output logic [NUM_DIV-1:0] loop_feedback_o,
    output logic nvm_write_ok_o,
    output logic [coc_pkg::NVM_CNT_W-1:0] nvm_bank_o,
    output logic serial_is_i2c_o,
    output logic serial_spi_3wire_o
);
    localparam int SEL_IDX = coc_pkg::SEL_W;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic oe_n_level;
    logic realign_level;
    logic hard_rst_level;
    logic up_rise;
    logic down_rise;
    logic sel_level;

    coc_edge_sync u_oe (.clk_i(clk_i), .resetn_i(resetn_i), .pin_i(output_disable_pin_n_i),
        .level_o(oe_n_level), .rise_o());
    // Inverted so its idle level matches the reset value
    coc_edge_sync u_sync (.clk_i(clk_i), .resetn_i(resetn_i), .pin_i(~realign_pin_n_i),
        .level_o(realign_level), .rise_o()); // [RQ23]
    coc_edge_sync u_hrst (.clk_i(clk_i), .resetn_i(resetn_i), .pin_i(~hard_reset_pin_n_i),
        .level_o(hard_rst_level), .rise_o());
    coc_edge_sync u_up (.clk_i(clk_i), .resetn_i(resetn_i), .pin_i(freq_step_up_i),
        .level_o(), .rise_o(up_rise)); // [RQ23]
    coc_edge_sync u_down (.clk_i(clk_i), .resetn_i(resetn_i), .pin_i(freq_step_down_i),
        .level_o(), .rise_o(down_rise)); // [RQ23]
    coc_edge_sync u_sel (.clk_i(clk_i), .resetn_i(resetn_i), .pin_i(serial_sel_pin_i),
        .level_o(sel_level), .rise_o());

    // ************************************************************
    // Control bit edges
    // ************************************************************
    logic soft_prev;
    logic sync_prev;
    logic hard_prev;
    logic sup_prev;
    logic sdn_prev;
    logic upd_prev;
    logic nvm_prev;
    logic realign_prev;

    wire soft_evt = soft_reset_bit_i & ~soft_prev;
    wire hard_evt = (hard_reset_bit_i & ~hard_prev) | hard_rst_level;
    wire realign_rise = realign_prev & ~realign_level; // [RQ13]
    wire realign_evt = realign_rise | (sync_bit_i & ~sync_prev); // [RQ13] [RQ14]
    wire step_up_evt = up_rise | (step_up_bit_i & ~sup_prev);
    wire step_down_evt = down_rise | (step_down_bit_i & ~sdn_prev);
    wire update_evt = numerator_update_i & ~upd_prev;
    wire nvm_evt = nvm_write_i & ~nvm_prev;
    wire global_off = oe_n_level; // [RQ1]

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            {soft_prev, sync_prev, hard_prev, sup_prev, sdn_prev, upd_prev, nvm_prev} <= '0;
            realign_prev <= 1'b0;
        end else begin
            soft_prev <= soft_reset_bit_i;
            sync_prev <= sync_bit_i;
            hard_prev <= hard_reset_bit_i;
            sup_prev <= step_up_bit_i;
            sdn_prev <= step_down_bit_i;
            upd_prev <= numerator_update_i;
            nvm_prev <= nvm_write_i;
            realign_prev <= realign_level;
        end
    end

    // ************************************************************
    // Skew and numerators per divider
    // ************************************************************
    logic first_load;

    genvar d;
    generate
        for (d = 0; d < NUM_DIV; d++) begin : g_div
            wire hit = step_target_i[d];
            wire sel_num = update_evt && (numerator_div_i == SEL_IDX'(d));

            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    applied_skew_o[d] <= coc_pkg::SKEW_DEFAULT;
                    numerator_o[d] <= '0;
                end else begin
                    if (hard_evt || first_load) begin
                        applied_skew_o[d] <= nvm_skew_i[d]; // [RQ11] [RQ9]
                    end else if (soft_evt) begin
                        applied_skew_o[d] <= divider_skew_setting_i[d]; // [RQ10] [RQ15]
                    end
                    if (sel_num) begin
                        numerator_o[d] <= numerator_i; // [RQ19] [RQ18]
                    end else if (hit && step_up_evt && !step_down_evt) begin
                        numerator_o[d] <= numerator_o[d] + freq_step_word_i; // [RQ17]
                    end else if (hit && step_down_evt && !step_up_evt) begin
                        numerator_o[d] <= numerator_o[d] - freq_step_word_i; // [RQ17]
                    end
                end
            end

            assign loop_feedback_o[d] = zero_delay_i ? feedback_input_i[d] : div_clk_i[d]; // [RQ20]
        end
    endgenerate

    // ************************************************************
    // Outputs: crosspoint, drivers, output dividers
    // ************************************************************
    genvar o;
    generate
        for (o = 0; o < NUM_OUT; o++) begin : g_out
            wire src = div_clk_i[out_cfg_i[o].src_sel]; // [RQ16]
            wire drv_bad = (vddo_level_i == coc_pkg::VDDO_1V8)
                && (out_cfg_i[o].cmos_drive_select == coc_pkg::DRV_LOWEST);
            coc_out_driver u_drv (.clk_i(clk_i), .resetn_i(resetn_i), .global_off_i(global_off),
                .cfg_i(out_cfg_i[o]), .src_clk_i(src), .pin_o(pin_o[o])); // [RQ2] [RQ4]

            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    drive_applied_o[o] <= coc_pkg::DRV_RESET;
                    rdiv_count_o[o] <= coc_pkg::RDIV_DEFAULT;
                end else begin
                    drive_applied_o[o] <= drv_bad ? coc_pkg::DRV_RESET
                        : out_cfg_i[o].cmos_drive_select; // [RQ8]
                    if (hard_evt || soft_evt || realign_evt) begin
                        rdiv_count_o[o] <= coc_pkg::RDIV_DEFAULT; // [RQ12] [RQ13]
                    end else begin
                        rdiv_count_o[o] <= rdiv_count_o[o] + 8'h01;
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // Stored configuration and serial select
    // ************************************************************
    wire nvm_room = (nvm_bank_o < coc_pkg::NVM_CNT_W'(coc_pkg::NVM_WRITES_MAX));

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            nvm_bank_o <= coc_pkg::NVM_CNT_RESET;
            nvm_write_ok_o <= 1'b1;
            first_load <= 1'b1;
            serial_is_i2c_o <= 1'b0;
            serial_spi_3wire_o <= 1'b0;
        end else begin
            first_load <= 1'b0;
            if (nvm_evt && nvm_room) begin
                nvm_bank_o <= nvm_bank_o + 2'h1; // [RQ21]
            end
            nvm_write_ok_o <= nvm_room && !(nvm_evt && nvm_bank_o == 2'h1);
            serial_is_i2c_o <= sel_level; // [RQ22]
            serial_spi_3wire_o <= ~sel_level & spi_3wire_i; // [RQ22]
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    property p_nvm_limit;
        @(posedge clk_i) disable iff (!resetn_i)
        nvm_bank_o <= 2'h2;
    endproperty
    a_nvm_limit: assert property (p_nvm_limit) else $error("too many nvm writes"); // [RQ21]

    property p_realign;
        @(posedge clk_i) disable iff (!resetn_i)
        realign_evt |=> rdiv_count_o[0] == coc_pkg::RDIV_DEFAULT;
    endproperty
    a_realign: assert property (p_realign) else $error("divider not realigned"); // [RQ13]

    property p_soft_skew;
        @(posedge clk_i) disable iff (!resetn_i)
        soft_evt && !hard_evt && !first_load
        |=> applied_skew_o[0] == $past(divider_skew_setting_i[0]);
    endproperty
    a_soft_skew: assert property (p_soft_skew) else $error("skew not applied"); // [RQ15]

    property p_no_soft_hold;
        @(posedge clk_i) disable iff (!resetn_i)
        !soft_evt && !hard_evt && !first_load |=> $stable(applied_skew_o[0]);
    endproperty
    a_no_soft_hold: assert property (p_no_soft_hold) else $error("skew changed early"); // [RQ10]

    property p_num_hold;
        @(posedge clk_i) disable iff (!resetn_i)
        !update_evt && !step_up_evt && !step_down_evt |=> $stable(numerator_o[0]);
    endproperty
    a_num_hold: assert property (p_num_hold) else $error("numerator moved"); // [RQ19]

    property p_step_up;
        @(posedge clk_i) disable iff (!resetn_i)
        step_up_evt && !step_down_evt && step_target_i[0] && !update_evt
        |=> numerator_o[0] == $past(numerator_o[0]) + $past(freq_step_word_i);
    endproperty
    a_step_up: assert property (p_step_up) else $error("step up wrong"); // [RQ17]

    property p_zdm;
        @(posedge clk_i) disable iff (!resetn_i)
        zero_delay_i |-> loop_feedback_o == feedback_input_i;
    endproperty
    a_zdm: assert property (p_zdm) else $error("feedback not external"); // [RQ20]

    property p_drive;
        @(posedge clk_i) disable iff (!resetn_i)
        vddo_level_i == coc_pkg::VDDO_1V8 |=> drive_applied_o[0] != coc_pkg::DRV_LOWEST;
    endproperty
    a_drive: assert property (p_drive) else $error("lowest drive at low supply"); // [RQ8]

    property p_hard_load;
        @(posedge clk_i) disable iff (!resetn_i)
        hard_evt |=> applied_skew_o[0] == $past(nvm_skew_i[0]);
    endproperty
    a_hard_load: assert property (p_hard_load) else $error("skew not reloaded"); // [RQ11]

    sequence s_sync_bit;
        sync_bit_i && !sync_prev;
    endsequence
    property p_sync_bit;
        @(posedge clk_i) disable iff (!resetn_i)
        s_sync_bit |=> rdiv_count_o[NUM_OUT-1] == coc_pkg::RDIV_DEFAULT;
    endproperty
    a_sync_bit: assert property (p_sync_bit) else $error("sync bit ignored"); // [RQ14]

    property p_serial_sel;
        @(posedge clk_i) disable iff (!resetn_i)
        serial_is_i2c_o |-> !serial_spi_3wire_o;
    endproperty
    a_serial_sel: assert property (p_serial_sel) else $error("3-wire set in I2C mode"); // [RQ22]
endmodule
`default_nettype wire

// ==== dv/coc_host_model.sv ====
// Purpose: Host side model driving strobes, pins, numerator writes and divider clocks
// Assumes: One clock; every strobe changes just after a rising edge
// Notes: Numerator bus shows inverted data once the update is done
`timescale 1ns/100ps
`default_nettype none
module coc_host_model (
    // Clock
    input wire logic clk_i,
    // Toward the device
    output logic [coc_pkg::NUM_DIV-1:0] div_clk_o,
    output logic [10:0] strobe_o,
    output logic [coc_pkg::NUM_W-1:0] num_o,
    output logic [2:0] num_div_o
);
    logic [7:0] cnt = 8'h00;
    initial begin
        div_clk_o = '0;
        strobe_o = '0;
        num_o = '0;
        num_div_o = '0;
    end
    // Divider clocks with periods of 4 to 64 cycles
    always @(posedge clk_i) begin
        cnt <= cnt + 8'h01;
        div_clk_o <= cnt[5:1];
    end
    // Strobe held, then low for two cycles before any next use
    task automatic pulse(input int idx, input int hold);
        @(posedge clk_i);
        strobe_o[idx] <= 1'b1;
        repeat (hold) @(posedge clk_i);
        strobe_o[idx] <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    // Numerator first, then its update strobe
    task automatic write_num(input logic [2:0] div, input logic [coc_pkg::NUM_W-1:0] val);
        @(posedge clk_i);
        num_o <= val;
        num_div_o <= div;
        pulse(5, 1);
        num_o <= ~val;
    endtask
endmodule
`default_nettype wire

// ==== dv/clock_output_control_bench.sv ====
// Purpose: Self-checking bench for the clock output control block
// Assumes: Host model supplies strobes, numerator writes and divider clocks
// Notes: Fixed waits follow the two-edge pin synchroniser latency
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (b)); end end
module clock_output_control_bench;
    localparam logic [43:0] NV = 44'h123_4567_89AB;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic oe_n = 1'b0;
    logic sel_pin = 1'b1;
    logic zd = 1'b0;
    logic spi3 = 1'b0;
    logic hit;
    logic [1:0] vddo = 2'h0;
    logic [1:0] exp_drv;
    logic [4:0] fb = 5'h00;
    logic [43:0] word = 44'h000_0000_1234;
    logic [4:0][15:0] skew_set = '0;
    logic [4:0][15:0] nvm_skew = {16'h0005, 16'h0004, 16'h0003, 16'h0002, 16'h0001};
    coc_pkg::coc_out_cfg_s [9:0] cfg;
    wire logic [10:0] strobe;
    wire logic [43:0] num;
    wire logic [2:0] num_div;
    wire logic [4:0] div_clk;
    coc_pkg::coc_pin_s [9:0] pin;
    logic [4:0][43:0] numerator;
    logic [4:0][15:0] applied_skew;
    logic [9:0][7:0] rdiv;
    logic [9:0][1:0] drv;
    logic [4:0] loopfb;
    logic [1:0] nvm_bank;
    logic is_i2c;
    logic spi3_o;
    logic nvm_ok;
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    initial forever #50 clk_i = ~clk_i;
    coc_host_model host (.clk_i(clk_i), .div_clk_o(div_clk), .strobe_o(strobe),
        .num_o(num), .num_div_o(num_div));
    coc_top uut (.clk_i(clk_i), .resetn_i(resetn_i), .output_disable_pin_n_i(oe_n),
        .realign_pin_n_i(~strobe[8]), .hard_reset_pin_n_i(~strobe[10]),
        .freq_step_up_i(strobe[7]), .freq_step_down_i(strobe[9]), .serial_sel_pin_i(sel_pin),
        .feedback_input_i(fb),
        .out_cfg_i(cfg), .vddo_level_i(vddo), .divider_skew_setting_i(skew_set),
        .nvm_skew_i(nvm_skew), .freq_step_word_i(word), .step_target_i(5'h05),
        .step_up_bit_i(strobe[3]), .step_down_bit_i(strobe[4]), .numerator_i(num),
        .numerator_div_i(num_div), .numerator_update_i(strobe[5]),
        .soft_reset_bit_i(strobe[1]), .hard_reset_bit_i(strobe[2]), .sync_bit_i(strobe[0]),
        .zero_delay_i(zd), .nvm_write_i(strobe[6]), .spi_3wire_i(spi3), .div_clk_i(div_clk),
        .pin_o(pin), .numerator_o(numerator), .applied_skew_o(applied_skew),
        .rdiv_count_o(rdiv), .drive_applied_o(drv), .loop_feedback_o(loopfb),
        .nvm_write_ok_o(nvm_ok), .nvm_bank_o(nvm_bank), .serial_is_i2c_o(is_i2c),
        .serial_spi_3wire_o(spi3_o));
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Pulse one strobe and watch for all output dividers back at their start count
    task automatic realign(input int idx);
        hit = 1'b0;
        fork
            host.pulse(idx, 4);
            repeat (16) begin
                @(posedge clk_i);
                #1;
                if (rdiv === {10{coc_pkg::RDIV_DEFAULT}}) hit = 1'b1;
            end
        join
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            give_verdict();
        end
    end
    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        for (int i = 0; i < 10; i++) begin
            cfg[i] = '0;
            cfg[i].disable_high = i[1] ^ i[0];
            cfg[i].async_disable = i[0];
            cfg[i].is_cmos = 1'b1;
            cfg[i].cmos_in_phase = i[2];
            cfg[i].cmos_drive_select = 2'h2;
            cfg[i].src_sel = 3'(i % 5);
        end
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1;
        tick(200);
        `CHK(applied_skew, nvm_skew)
        for (int i = 0; i < 10; i++) `CHK(pin[i].driver_on, 1'b1)
        for (int k = 0; k < 16; k++) begin
            tick(1);
            for (int i = 0; i < 10; i++) `CHK(pin[i].complementary_output, pin[i].true_output ^ ~cfg[i].cmos_in_phase)
        end
        for (int s = 0; s < 2; s++) begin
            for (int d = 1; d < 4; d++) begin
                @(posedge clk_i);
                vddo <= s[0] ? coc_pkg::VDDO_1V8 : 2'h0;
                for (int i = 0; i < 10; i++) cfg[i].cmos_drive_select <= d[1:0];
                tick(3);
                exp_drv = (s == 1 && d == 1) ? coc_pkg::DRV_RESET : d[1:0];
                for (int i = 0; i < 10; i++) `CHK(drv[i], exp_drv)
            end
        end
        @(posedge clk_i);
        cfg[2].reg_disable <= 1'b1;
        cfg[3].reg_disable <= 1'b1;
        tick(3);
        `CHK(pin[3].driver_on, 1'b0)
        tick(80);
        `CHK(pin[2].driver_on, 1'b0)
        `CHK(pin[2].true_output, cfg[2].disable_high)
        `CHK(pin[3].true_output, cfg[3].disable_high)
        `CHK(pin[4].driver_on, 1'b1)
        @(posedge clk_i);
        oe_n <= 1'b1;
        tick(80);
        for (int i = 0; i < 10; i++) `CHK(pin[i].driver_on, 1'b0)
        for (int i = 0; i < 10; i++) `CHK(pin[i].true_output, cfg[i].disable_high)
        @(posedge clk_i);
        oe_n <= 1'b0;
        skew_set <= {5{16'h0ABC}};
        tick(4);
        `CHK(applied_skew, nvm_skew)
        host.pulse(1, 1);
        tick(1);
        `CHK(applied_skew, {5{16'h0ABC}})
        realign(2);
        `CHK(hit, 1'b1)
        `CHK(applied_skew, nvm_skew)
        realign(0);
        `CHK(hit, 1'b1)
        realign(8);
        `CHK(hit, 1'b1)
        realign(1);
        `CHK(hit, 1'b1)
        realign(10);
        `CHK(hit, 1'b1)
        `CHK(applied_skew, nvm_skew)
        host.write_num(3'h2, NV);
        tick(4);
        `CHK(numerator[2], NV)
        `CHK(numerator[1], 44'h0)
        host.pulse(3, 1);
        tick(1);
        `CHK(numerator[2], NV + word)
        host.pulse(4, 1);
        tick(1);
        `CHK(numerator[2], NV)
        host.pulse(7, 10);
        tick(4);
        `CHK(numerator[2], NV + word)
        host.pulse(9, 10);
        tick(4);
        `CHK(numerator[2], NV)
        `CHK(loopfb, div_clk)
        @(posedge clk_i);
        zd <= 1'b1;
        fb <= 5'h15;
        tick(2);
        `CHK(loopfb, 5'h15)
        for (int n = 1; n < 4; n++) begin
            host.pulse(6, 1);
            tick(1);
            `CHK(nvm_bank, (n > 2) ? 2'h2 : n[1:0])
            `CHK(nvm_ok, n < 2)
        end
        for (int s = 0; s < 4; s++) begin
            @(posedge clk_i);
            sel_pin <= s[1];
            spi3 <= s[0];
            tick(5);
            `CHK(is_i2c, s[1])
            `CHK(spi3_o, s[0] & ~s[1])
        end
        give_verdict();
    end
endmodule
`default_nettype wire
